// file: src/acr_adc_map.vh
// register offsets, field positions, reset values and timing counts of the converter block
`ifndef ACR_ADC_MAP_VH
`define ACR_ADC_MAP_VH

// ****************************************
// register offsets
// ****************************************
`define ACR_OFS_CTRL_STATUS 8'h70
`define ACR_OFS_RESULT_HIGH 8'h71
`define ACR_OFS_RESULT_LOW 8'h72

// ****************************************
// control/status fields
// ****************************************
`define ACR_BIT_EOC 7
`define ACR_BIT_SPEED 6
`define ACR_BIT_ON 5
`define ACR_BIT_RSVD 4
`define ACR_SEL_MSB 3
`define ACR_SEL_LSB 0

// ****************************************
// reset values
// ****************************************
`define ACR_RST_CTRL 8'h00
`define ACR_RST_RESULT 10'h000

// ****************************************
// timing counts
// ****************************************
`define ACR_DIV_SLOW 3'h4
`define ACR_DIV_FAST 3'h2
`define ACR_CONV_ADC_CLOCKS 5'h18

`endif

// file: src/acr_adc_sar.v
// successive-approximation sequencer, one bit per two converter clock ticks
`timescale 1ns/1ns
module acr_adc_sar #(
  parameter WIDTH = 10
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire i_run,
  input wire i_restart,
  input wire i_tick,
  input wire i_cmp_above,
  output reg [WIDTH-1:0] o_trial,
  output reg o_done,
  output reg [WIDTH-1:0] o_result
);

  // ****************************************
  // state
  // ****************************************
  reg [WIDTH-1:0] bit_reg;
  reg [WIDTH-1:0] acc_reg;
  reg [1:0] settle_reg;
  reg phase_reg;
  wire [WIDTH-1:0] kept;

  assign kept = i_cmp_above ? o_trial : (o_trial & ~bit_reg);

  always @(posedge i_sys_clk) begin
    o_done <= 1'b0;
    if (!i_rst_n) begin
      bit_reg <= {WIDTH{1'b0}};
      acc_reg <= {WIDTH{1'b0}};
      o_trial <= {WIDTH{1'b0}};
      o_result <= {WIDTH{1'b0}};
      settle_reg <= 2'h0;
      phase_reg <= 1'b0;
    end else if (!i_run || i_restart) begin
      // any ongoing step sequence is dropped, sampling restarts
      bit_reg <= {1'b1, {(WIDTH-1){1'b0}}};
      acc_reg <= {WIDTH{1'b0}};
      o_trial <= {1'b1, {(WIDTH-1){1'b0}}};
      settle_reg <= 2'h0;
      phase_reg <= 1'b0;
    end else if (i_tick) begin
      if (settle_reg != 2'h3) begin
        // sample-and-hold time before the first comparison
        settle_reg <= settle_reg + 2'h1;
      end else if (!phase_reg) begin
        // two ticks a bit: the trial needs three clocks to come back synchronised
        phase_reg <= 1'b1;
      end else if (bit_reg[0]) begin
        phase_reg <= 1'b0;
        o_result <= kept;
        o_done <= 1'b1;
        bit_reg <= {1'b1, {(WIDTH-1){1'b0}}};
        acc_reg <= {WIDTH{1'b0}};
        o_trial <= {1'b1, {(WIDTH-1){1'b0}}};
        settle_reg <= 2'h0;
      end else begin
        phase_reg <= 1'b0;
        acc_reg <= kept;
        bit_reg <= bit_reg >> 1;
        o_trial <= kept | (bit_reg >> 1);
      end
    end
  end

endmodule

// file: src/acr_adc_ctrl.v
// register file and control of the 10-bit converter: control/status and result bytes
`timescale 1ns/1ns
`include "acr_adc_map.vh"
module acr_adc_ctrl #(
  parameter RES_BITS = 10,
  parameter SEL_BITS = 4
) (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  input wire i_cmp_above,
  output reg [RES_BITS-1:0] o_dac_trial,
  output reg [SEL_BITS-1:0] o_input_select,
  output reg o_converter_on,
  output reg o_adc_clk_tick
);

  // ****************************************
  // constants
  // ****************************************
  // reset image of the control byte, taken apart field by field
  localparam [7:0] RST_CTRL = `ACR_RST_CTRL;
  // converter control states
  localparam [1:0] ST_OFF = 2'h0;
  localparam [1:0] ST_ARM = 2'h1;
  localparam [1:0] ST_RUN = 2'h2;
  localparam [1:0] ST_ABORT = 2'h3;

  // ****************************************
  // registers
  // ****************************************
  reg eoc_reg;
  reg speed_reg;
  reg on_reg;
  reg rsvd_reg;
  reg [SEL_BITS-1:0] sel_reg;
  reg [2:0] div_reg;
  reg tick_reg;
  reg cmp_meta_reg;
  reg cmp_sync_reg;
  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg [2:0] div_next;
  reg tick_next;
  wire restart;
  wire set_eoc;
  wire clr_eoc;
  wire wr_ctrl;
  wire rd_high;
  wire sel_change;
  wire [2:0] div_limit;
  wire [RES_BITS-1:0] trial;
  wire done;
  wire [RES_BITS-1:0] result;
  reg [7:0] rdata_next;

  // ****************************************
  // decode
  // ****************************************
  function hit;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      hit = (addr == ofs);
    end
  endfunction

  assign wr_ctrl = i_wr && hit(i_addr, `ACR_OFS_CTRL_STATUS);
  assign rd_high = i_rd && hit(i_addr, `ACR_OFS_RESULT_HIGH);
  assign sel_change = wr_ctrl && (i_wdata[`ACR_SEL_MSB:`ACR_SEL_LSB] != sel_reg);
  assign div_limit = speed_reg ? `ACR_DIV_FAST : `ACR_DIV_SLOW;
  assign set_eoc = done && !sel_change && on_reg;
  assign clr_eoc = wr_ctrl || rd_high;

  // ****************************************
  // control/status register
  // ****************************************
  // the flag bit of a written value has no field here and is ignored
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      speed_reg <= RST_CTRL[`ACR_BIT_SPEED];
    end else if (wr_ctrl) begin
      speed_reg <= i_wdata[`ACR_BIT_SPEED];
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      on_reg <= RST_CTRL[`ACR_BIT_ON];
    end else if (wr_ctrl) begin
      on_reg <= i_wdata[`ACR_BIT_ON];
    end
  end

  // bit 4 is stored as written so software sees its own value back
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      rsvd_reg <= RST_CTRL[`ACR_BIT_RSVD];
    end else if (wr_ctrl) begin
      rsvd_reg <= i_wdata[`ACR_BIT_RSVD];
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sel_reg <= RST_CTRL[`ACR_SEL_MSB:`ACR_SEL_LSB];
    end else if (wr_ctrl) begin
      sel_reg <= i_wdata[`ACR_SEL_MSB:`ACR_SEL_LSB];
    end
  end

  // a completion in the same cycle as a clear wins, unless the clearing write changes the input select
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      eoc_reg <= RST_CTRL[`ACR_BIT_EOC];
    end else if (set_eoc) begin
      eoc_reg <= 1'b1;
    end else if (clr_eoc) begin
      eoc_reg <= 1'b0;
    end
  end

  // ****************************************
  // converter clock divider
  // ****************************************
  always @* begin
    div_next = div_reg + 3'h1;
    tick_next = 1'b0;
    if (div_reg >= div_limit - 3'h1) begin
      div_next = 3'h0;
      tick_next = 1'b1;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n || !on_reg) begin
      // switched off, the divider stands still to save power
      div_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      tick_reg <= tick_next;
    end
  end

  // ****************************************
  // comparator sync
  // ****************************************
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cmp_meta_reg <= 1'b0;
    end else begin
      cmp_meta_reg <= i_cmp_above;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      cmp_sync_reg <= 1'b0;
    end else begin
      cmp_sync_reg <= cmp_meta_reg;
    end
  end

  // ****************************************
  // converter control state
  // ****************************************
  // restart on a new input, or when switched on afresh
  assign restart = (state_reg == ST_ARM) || (state_reg == ST_ABORT);

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (wr_ctrl && i_wdata[`ACR_BIT_ON]) begin
          state_next = ST_ARM;
        end
      end
      ST_ARM, ST_ABORT: begin
        if (wr_ctrl && !i_wdata[`ACR_BIT_ON]) begin
          state_next = ST_OFF;
        end else if (sel_change) begin
          state_next = ST_ABORT;
        end else begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wr_ctrl && !i_wdata[`ACR_BIT_ON]) begin
          state_next = ST_OFF;
        end else if (sel_change) begin
          state_next = ST_ABORT;
        end
      end
      default: begin
        state_next = ST_OFF;
      end
    endcase
  end

  // free-running sequencer: each result overwrites the last
  acr_adc_sar #(
    .WIDTH(RES_BITS)
  ) u_sar (
    .i_sys_clk(i_sys_clk),
    .i_rst_n(i_rst_n),
    .i_run(on_reg),
    .i_restart(restart || sel_change),
    .i_tick(tick_reg),
    .i_cmp_above(cmp_sync_reg),
    .o_trial(trial),
    .o_done(done),
    .o_result(result)
  );

  // ****************************************
  // read port
  // ****************************************
  // the result is not latched; a late high read may pair with an older low part
  function [7:0] read_byte;
    input [7:0] addr;
    input [7:0] status;
    input [RES_BITS-1:0] value;
    begin
      case (addr)
        `ACR_OFS_CTRL_STATUS: begin
          read_byte = status;
        end
        `ACR_OFS_RESULT_HIGH: begin
          read_byte = value[RES_BITS-1:2];
        end
        `ACR_OFS_RESULT_LOW: begin
          read_byte = {6'h00, value[1:0]};
        end
        default: begin
          read_byte = 8'h00;
        end
      endcase
    end
  endfunction

  always @* begin
    rdata_next = read_byte(i_addr, {eoc_reg, speed_reg, on_reg, rsvd_reg, sel_reg}, result);
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else begin
      // the read byte stands one cycle only, then the bus is quiet again
      o_rdata <= i_rd ? rdata_next : 8'h00;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_dac_trial <= {RES_BITS{1'b0}};
    end else begin
      o_dac_trial <= trial;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_input_select <= {SEL_BITS{1'b0}};
    end else begin
      o_input_select <= sel_reg;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_converter_on <= 1'b0;
    end else begin
      o_converter_on <= on_reg;
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_adc_clk_tick <= 1'b0;
    end else begin
      o_adc_clk_tick <= tick_reg;
    end
  end

endmodule

// file: verification/acr_adc_mux_model.sv
// analog multiplexer model with fixed levels
`timescale 1ns/1ns
module acr_adc_mux_model (
  input wire [3:0] i_input_select,
  input wire [9:0] i_dac_trial,
  output wire o_cmp_above
);
  // steady levels keep every conversion result known in advance
  wire [9:0] level = {i_input_select, 6'h03} ^ 10'h0A5;
  assign o_cmp_above = level >= i_dac_trial;
endmodule

// file: verification/acr_adc_chk.sv
// assertion checker for the converter register block
`timescale 1ns/1ns
module acr_adc_chk (
  input wire i_sys_clk,
  input wire i_rst_n,
  input wire [7:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  input wire [7:0] o_rdata,
  input wire [3:0] o_input_select,
  input wire o_converter_on,
  input wire o_adc_clk_tick
);
  default clocking dc @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  sel_follow_a: assert property (
    i_wr && i_addr == 8'h70 |-> ##2 o_input_select == $past(i_wdata[3:0], 2)) else $error("sel");
  on_follow_a: assert property (
    i_wr && i_addr == 8'h70 |-> ##2 o_converter_on == $past(i_wdata[5], 2)) else $error("on");
  off_quiet_a: assert property (
    !o_converter_on && !$past(o_converter_on) && !$past(o_converter_on, 2) |-> !o_adc_clk_tick)
    else $error("tick while off");
  tick_pulse_a: assert property (o_adc_clk_tick |=> !o_adc_clk_tick) else $error("tick");
  unmapped_rd_a: assert property (
    i_rd && (i_addr < 8'h70 || i_addr > 8'h72) |=> o_rdata == 8'h00) else $error("unmapped");
  low_zero_a: assert property (
    i_rd && i_addr == 8'h72 |=> o_rdata[7:2] == 6'h00) else $error("low byte");
  rd_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("idle");
  reset_zero_a: assert property (
    $rose(i_rst_n) |-> o_rdata == 8'h00 && !o_converter_on && o_input_select == 4'h0)
    else $error("reset");
endmodule

// file: verification/tb_top.sv
// self-checking bench for the converter register block
`timescale 1ns/1ns
module tb_top;
  reg i_sys_clk = 1'b0;
  reg i_rst_n = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [7:0] i_wdata = 8'h00;
  reg i_wr = 1'b0;
  reg i_rd = 1'b0;
  wire [7:0] o_rdata;
  wire cmp;
  wire [9:0] trial;
  wire [3:0] sel;
  wire on;
  wire tick;
  integer error_cnt = 0;
  integer checks = 0;
  integer i;
  integer n;
  reg [7:0] got;
  reg [3:0] s;
  reg [9:0] lvl;
`define CHK(g, e) begin checks = checks + 1; if ((g) !== (e)) begin \
  error_cnt = error_cnt + 1; $display("[ERR] %0t got %h exp %h", $time, g, e); end end
  always #4 i_sys_clk = ~i_sys_clk;
  acr_adc_ctrl acr_adc_ctrl_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cmp_above(cmp),
    .o_dac_trial(trial), .o_input_select(sel), .o_converter_on(on), .o_adc_clk_tick(tick));
  acr_adc_mux_model acr_adc_mux_model_i (.i_input_select(sel), .i_dac_trial(trial),
    .o_cmp_above(cmp));
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge i_sys_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
    end
  endtask
  task rd(input [7:0] a);
    begin
      @(posedge i_sys_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 got = o_rdata;
    end
  endtask
  task wait_eoc;
    begin
      n = 0;
      got = 8'h00;
      while (got[7] !== 1'b1 && n < 300) begin
        rd(8'h70);
        n = n + 1;
      end
      `CHK(got[7], 1'b1)
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    finish_test;
  end
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    rd(8'h70); `CHK(got, 8'h00)
    rd(8'h71); `CHK(got, 8'h00)
    rd(8'h72); `CHK(got, 8'h00)
    wr(8'h73, 8'hFF);
    rd(8'h73); `CHK(got, 8'h00)
    // each write after the first moves channel while converting, so a stale result would show
    for (i = 0; i < 4; i = i + 1) begin
      s = i * 5;
      lvl = {s, 6'h03} ^ 10'h0A5;
      wr(8'h70, {1'b1, i[0], 2'b10, s});
      rd(8'h70); `CHK(got, {1'b0, i[0], 2'b10, s})
      @(posedge tick);
      #1 n = 0;
      do begin
        @(posedge i_sys_clk);
        #1 n = n + 1;
      end while (tick !== 1'b1 && n < 9);
      `CHK(n, (i[0] ? 2 : 4))
      wait_eoc;
      rd(8'h72); `CHK(got, {6'h00, lvl[1:0]})
      rd(8'h71); `CHK(got, lvl[9:2])
      rd(8'h70); `CHK(got[7], 1'b0)
      $display("channel test %0d done", i);
    end
    wait_eoc;
    wr(8'h70, 8'h6F);
    rd(8'h70); `CHK(got, 8'h6F)
    wr(8'h70, 8'h00);
    repeat (80) @(posedge i_sys_clk);
    #1 `CHK(on, 1'b0)
    rd(8'h70); `CHK(got, 8'h00)
    rd(8'h71); `CHK(got, lvl[9:2])
    $display("off test done");
    finish_test;
  end
endmodule
bind acr_adc_ctrl acr_adc_chk acr_adc_chk_i (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_input_select(o_input_select), .o_converter_on(o_converter_on),
  .o_adc_clk_tick(o_adc_clk_tick));
